// [src/transceiver_config_registers.sv]
// Configuration register group with framed serial command parser and fault engine
//
// Notes on behaviour
// - Four destination ID bytes, volatile and non-volatile
// - Destination ID used only in ID mode
// - Each ID byte accessed by single commands
// - Short ID is byte1 high, byte0 low
// - Fault code ANDed with fault mask
// - Nonzero masked result raises fault line
// - Zero result: store code, line stays low
// - Reading fault code clears line
// - Mask bits 08,10,20 select fault groups
// - Mask bit 40 packet errors; ff all
// - Read: ff 02 fe addr; answer 06 addr value
// - Write: ff 02 addr value
// - Hold radio traffic while command line low
// - Release held traffic when command line high
// - Gain mode codes 0 to 3 decoded
// - Gain mode resets to automatic
// - Signal level compensated for gain mode
// - Compatibility register 0 off, 1 on
// - Newer fault overwrites unread code
`include "xcvr_cfg_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module transceiver_config_registers
  import xcvr_cfg_pkg::*;
#(
  parameter int RBUF_DEPTH = 16,
  parameter int RBUF_AW = 4,
  parameter logic [7:0] OFS_HIGH_SENS = 8'h00,
  parameter logic [7:0] OFS_MID_LIN = 8'h07,
  parameter logic [7:0] OFS_HIGH_LIN = 8'h0a
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  input wire logic cmd_line_n,
  input wire logic uid_mode_en,
  input wire fault_evt_t fault_in,
  output logic fault_line,
  input wire logic radio_valid,
  input wire logic [7:0] radio_data,
  output logic traffic_valid,
  output logic [7:0] traffic_data,
  input wire logic traffic_ready,
  input wire logic [7:0] rssi_raw,
  output logic [7:0] rssi_comp,
  output radio_cfg_t cfg
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (RBUF_DEPTH < 2 || RBUF_DEPTH != (1 << RBUF_AW)) begin : g_bad_depth
    $error("RBUF_DEPTH must be a power of two equal to 2**RBUF_AW");
  end

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // True when the offset lies in a writable range; the unmapped offsets 6d and 22 fail
  function automatic logic addr_writable(input logic [7:0] a);
    addr_writable = (a >= `ADDR_UID3 && a <= `ADDR_FAULT_MASK) ||
                    (a >= `ADDR_HOLD_TRAFFIC && a <= `ADDR_LEGACY_COMPAT) ||
                    (a >= `ADDR_UID3_NV && a <= `ADDR_FAULT_MASK_NV) ||
                    (a >= `ADDR_HOLD_TRAFFIC_NV && a <= `ADDR_LEGACY_COMPAT_NV);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  parse_state_t state_reg, state_next; // Parser state
  logic [7:0] addr_reg; // Address of the write frame in flight
  logic [23:0] rsp_shift_reg; // Answer bytes, first byte on top
  logic [1:0] rsp_cnt_reg; // Answer bytes still to send
  logic [7:0] uid_v_reg [4]; // Volatile ID, index = byte number
  logic [7:0] uid_nv_reg [4]; // Non-volatile ID copy
  logic [7:0] fault_mask_reg, fault_mask_nv_reg;
  logic [7:0] hold_traffic_reg, hold_traffic_nv_reg;
  logic [7:0] rx_gain_mode_reg, rx_gain_mode_nv_reg;
  logic [7:0] legacy_compat_reg, legacy_compat_nv_reg;
  logic [7:0] fault_code_reg; // Last fault code
  logic fault_line_reg; // Pending unmasked fault
  logic cmd_sync1_reg, cmd_sync2_reg; // Command line synchroniser
  logic [7:0] rbuf_mem [RBUF_DEPTH]; // Held radio bytes
  logic [RBUF_AW:0] wr_ptr_reg, rd_ptr_reg;
  logic [7:0] rssi_comp_reg;
  logic ovf_evt; // Radio byte lost to a full buffer, read by the fault engine

  // ----------------------------------------
  // Command byte decode
  // ----------------------------------------
  wire logic byte_take = cmd_valid && cmd_ready;
  wire logic is_header = cmd_data == `CMD_HEADER;
  wire logic is_size = cmd_data == `CMD_SIZE;
  wire logic is_escape = cmd_data == `CMD_ESCAPE;
  wire logic do_write = byte_take && state_reg == ST_WVAL;
  wire logic wr_ok = do_write && addr_writable(addr_reg);
  wire logic wr_fail = do_write && !addr_writable(addr_reg);
  wire logic do_read = byte_take && state_reg == ST_RADDR;
  wire logic rd_fault = do_read && cmd_data == `ADDR_FAULT_CODE;
  wire logic [7:0] rd_value;
  wire logic [1:0] uid_v_idx = 2'(`ADDR_UID0 - addr_reg);
  wire logic [1:0] uid_nv_idx = 2'(`ADDR_UID0_NV - addr_reg);
  wire logic [1:0] rd_v_idx = 2'(`ADDR_UID0 - cmd_data);
  wire logic [1:0] rd_nv_idx = 2'(`ADDR_UID0_NV - cmd_data);

  assign cmd_ready = state_reg != ST_RESP;

  // Readback select, one byte per access
  assign rd_value =
    (cmd_data >= `ADDR_UID3 && cmd_data <= `ADDR_UID0) ? uid_v_reg[rd_v_idx] :
    (cmd_data >= `ADDR_UID3_NV && cmd_data <= `ADDR_UID0_NV) ? uid_nv_reg[rd_nv_idx] :
    (cmd_data == `ADDR_FAULT_MASK) ? fault_mask_reg :
    (cmd_data == `ADDR_FAULT_MASK_NV) ? fault_mask_nv_reg :
    (cmd_data == `ADDR_HOLD_TRAFFIC) ? hold_traffic_reg :
    (cmd_data == `ADDR_HOLD_TRAFFIC_NV) ? hold_traffic_nv_reg :
    (cmd_data == `ADDR_RX_GAIN_MODE) ? rx_gain_mode_reg :
    (cmd_data == `ADDR_RX_GAIN_MODE_NV) ? rx_gain_mode_nv_reg :
    (cmd_data == `ADDR_LEGACY_COMPAT) ? legacy_compat_reg :
    (cmd_data == `ADDR_LEGACY_COMPAT_NV) ? legacy_compat_nv_reg :
    (cmd_data == `ADDR_FAULT_CODE) ? fault_code_reg : 8'h00;

  // ----------------------------------------
  // Parser next state
  // ----------------------------------------
  // One byte per step, strictly in arrival order
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (byte_take && is_header) state_next = ST_SIZE;
      ST_SIZE: if (byte_take) state_next = is_size ? ST_SEL : ST_IDLE;
      ST_SEL: if (byte_take) state_next = is_escape ? ST_RADDR : ST_WVAL;
      ST_RADDR: if (byte_take) state_next = ST_RESP;
      ST_WVAL: if (byte_take) state_next = ST_IDLE;
      ST_RESP: if (rsp_ready && rsp_cnt_reg == 2'd1) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Parser registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      addr_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      // Write address follows the size byte directly
      if (byte_take && state_reg == ST_SEL) addr_reg <= cmd_data;
    end
  end

  // ----------------------------------------
  // Answer shifter
  // ----------------------------------------
  // Ack, address echo, value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_shift_reg <= 24'h000000;
      rsp_cnt_reg <= 2'd0;
    end else if (do_read) begin
      rsp_shift_reg <= {`RSP_ACK, cmd_data, rd_value};
      rsp_cnt_reg <= 2'd3;
    end else if (state_reg == ST_RESP && rsp_ready) begin
      rsp_shift_reg <= {rsp_shift_reg[15:0], 8'h00};
      rsp_cnt_reg <= rsp_cnt_reg - 2'd1;
    end
  end

  assign rsp_valid = state_reg == ST_RESP;
  assign rsp_data = rsp_shift_reg[23:16];

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Byte writes land in one register only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        uid_v_reg[i] <= `RST_UID;
        uid_nv_reg[i] <= `RST_UID;
      end
      fault_mask_reg <= `RST_FAULT_MASK;
      fault_mask_nv_reg <= `RST_FAULT_MASK;
      hold_traffic_reg <= `RST_HOLD_TRAFFIC;
      hold_traffic_nv_reg <= `RST_HOLD_TRAFFIC;
      rx_gain_mode_reg <= `RST_RX_GAIN_MODE;
      rx_gain_mode_nv_reg <= `RST_RX_GAIN_MODE;
      legacy_compat_reg <= `RST_LEGACY_COMPAT;
      legacy_compat_nv_reg <= `RST_LEGACY_COMPAT;
    end else if (wr_ok) begin
      if (addr_reg >= `ADDR_UID3 && addr_reg <= `ADDR_UID0) uid_v_reg[uid_v_idx] <= cmd_data;
      if (addr_reg >= `ADDR_UID3_NV && addr_reg <= `ADDR_UID0_NV) uid_nv_reg[uid_nv_idx] <= cmd_data;
      if (addr_reg == `ADDR_FAULT_MASK) fault_mask_reg <= cmd_data;
      if (addr_reg == `ADDR_FAULT_MASK_NV) fault_mask_nv_reg <= cmd_data;
      if (addr_reg == `ADDR_HOLD_TRAFFIC) hold_traffic_reg <= cmd_data;
      if (addr_reg == `ADDR_HOLD_TRAFFIC_NV) hold_traffic_nv_reg <= cmd_data;
      if (addr_reg == `ADDR_RX_GAIN_MODE) rx_gain_mode_reg <= cmd_data;
      if (addr_reg == `ADDR_RX_GAIN_MODE_NV) rx_gain_mode_nv_reg <= cmd_data;
      if (addr_reg == `ADDR_LEGACY_COMPAT) legacy_compat_reg <= cmd_data;
      if (addr_reg == `ADDR_LEGACY_COMPAT_NV) legacy_compat_nv_reg <= cmd_data;
    end
  end

  // ----------------------------------------
  // Decoded configuration
  // ----------------------------------------
  // Upper bits of the gain register are ignored
  wire gain_mode_t gain_mode = gain_mode_t'(rx_gain_mode_reg[1:0]);
  assign cfg.dest_uid = {uid_v_reg[3], uid_v_reg[2], uid_v_reg[1], uid_v_reg[0]};
  assign cfg.dest_uid_short = {uid_v_reg[1], uid_v_reg[0]};
  assign cfg.uid_target_valid = uid_mode_en;
  assign cfg.gain_mode = gain_mode;
  assign cfg.legacy_compat_en = legacy_compat_reg == `COMPAT_ON;

  // ----------------------------------------
  // Fault engine
  // ----------------------------------------
  // Outside events take priority over our own
  wire fault_evt_t fault_now = fault_in.valid ? fault_in :
    wr_fail ? fault_evt_t'{valid: 1'b1, code: `CODE_REG_WRITE_FAILURE} :
    ovf_evt ? fault_evt_t'{valid: 1'b1, code: `CODE_RADIO_BUFFER_OVERFLOW} :
    fault_evt_t'{valid: 1'b0, code: 8'h00};
  wire logic [7:0] fault_masked = fault_now.code & fault_mask_reg;
  wire logic fault_raise = fault_now.valid && fault_masked != 8'h00;

  // Code always stored; a new unmasked event beats a same-cycle clearing read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_code_reg <= `RST_FAULT_CODE;
      fault_line_reg <= 1'b0;
    end else begin
      if (fault_now.valid) fault_code_reg <= fault_now.code;
      if (fault_raise) fault_line_reg <= 1'b1;
      else if (rd_fault) fault_line_reg <= 1'b0;
    end
  end

  assign fault_line = fault_line_reg;

  // ----------------------------------------
  // Command line synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_sync1_reg <= 1'b1;
      cmd_sync2_reg <= 1'b1;
    end else begin
      cmd_sync1_reg <= cmd_line_n;
      cmd_sync2_reg <= cmd_sync1_reg;
    end
  end

  // ----------------------------------------
  // Radio traffic buffer
  // ----------------------------------------
  // Every byte goes through the buffer; with hold off it costs one cycle
  wire logic holding = hold_traffic_reg == `HOLD_ON && !cmd_sync2_reg;
  wire logic rbuf_empty = wr_ptr_reg == rd_ptr_reg;
  wire logic rbuf_full = wr_ptr_reg == {~rd_ptr_reg[RBUF_AW], rd_ptr_reg[RBUF_AW-1:0]};
  assign ovf_evt = radio_valid && rbuf_full;
  wire logic rbuf_push = radio_valid && !rbuf_full;
  wire logic rbuf_pop = traffic_valid && traffic_ready;

  // Drain stops only while holding
  assign traffic_valid = !rbuf_empty && !holding;
  assign traffic_data = rbuf_mem[rd_ptr_reg[RBUF_AW-1:0]];

  // Buffer storage, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (rbuf_push) rbuf_mem[wr_ptr_reg[RBUF_AW-1:0]] <= radio_data;
  end

  // Buffer pointers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (rbuf_push) wr_ptr_reg <= wr_ptr_reg + {{RBUF_AW{1'b0}}, 1'b1};
      if (rbuf_pop) rd_ptr_reg <= rd_ptr_reg + {{RBUF_AW{1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Signal level compensation
  // ----------------------------------------
  // Automatic mode needs no offset here; the gain loop reports its own
  wire logic [7:0] gain_ofs = (gain_mode == GAIN_MID_LIN) ? OFS_MID_LIN :
                              (gain_mode == GAIN_HIGH_LIN) ? OFS_HIGH_LIN :
                              (gain_mode == GAIN_HIGH_SENS) ? OFS_HIGH_SENS : 8'h00;

  // Registered compensated level
  always_ff @(posedge sys_clk) begin
    if (rst) rssi_comp_reg <= 8'h00;
    else rssi_comp_reg <= rssi_raw + gain_ofs;
  end

  assign rssi_comp = rssi_comp_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_read_answer;
    logic [7:0] a;
    @(posedge sys_clk) disable iff (rst)
    (do_read, a = cmd_data) |=> rsp_valid && rsp_data == `RSP_ACK && rsp_shift_reg[15:8] == a;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

  property p_write_lands;
    @(posedge sys_clk) disable iff (rst)
    wr_ok && addr_reg == `ADDR_FAULT_MASK |=> fault_mask_reg == $past(cmd_data);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("mask write lost");

  property p_fault_raise;
    @(posedge sys_clk) disable iff (rst)
    fault_now.valid && (fault_now.code & fault_mask_reg) != 8'h00 |=> fault_line;
  endproperty
  a_fault_raise: assert property (p_fault_raise) else $error("fault line not raised");

  property p_fault_quiet;
    @(posedge sys_clk) disable iff (rst)
    !fault_line && fault_now.valid && fault_masked == 8'h00 |=> !fault_line && fault_code_reg == $past(fault_now.code);
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("masked fault misbehaved");

  property p_fault_clear;
    @(posedge sys_clk) disable iff (rst)
    rd_fault && !fault_raise |=> !fault_line;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("read did not clear line");

  property p_hold;
    @(posedge sys_clk) disable iff (rst)
    hold_traffic_reg == `HOLD_ON && !cmd_sync2_reg |-> !traffic_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("traffic leaked while held");

  property p_pass;
    @(posedge sys_clk) disable iff (rst)
    hold_traffic_reg != `HOLD_ON && rbuf_push && rbuf_empty |=> traffic_valid && traffic_data == $past(radio_data);
  endproperty
  a_pass: assert property (p_pass) else $error("traffic not passed");

  property p_bad_header;
    @(posedge sys_clk) disable iff (rst)
    state_reg == ST_IDLE && byte_take && !is_header |=> state_reg == ST_IDLE;
  endproperty
  a_bad_header: assert property (p_bad_header) else $error("bad header accepted");

  property p_short_uid;
    @(posedge sys_clk) disable iff (rst)
    cfg.dest_uid_short == cfg.dest_uid[15:0];
  endproperty
  a_short_uid: assert property (p_short_uid) else $error("short id mismatch");

  c_read: cover property (@(posedge sys_clk) disable iff (rst) do_read ##[1:20] state_reg == ST_IDLE);
  c_write: cover property (@(posedge sys_clk) disable iff (rst) wr_ok);
  c_hold_release: cover property (@(posedge sys_clk) disable iff (rst) holding && !rbuf_empty ##[1:50] rbuf_pop);
  c_fault: cover property (@(posedge sys_clk) disable iff (rst) fault_raise ##[1:50] rd_fault);
endmodule // transceiver_config_registers
`default_nettype wire

// [src/xcvr_cfg_regs.svh]
// Register offsets, command bytes, field values and reset values of the configuration group
`ifndef XCVR_CFG_REGS_SVH
`define XCVR_CFG_REGS_SVH
// ----------------------------------------
// Command framing bytes
// ----------------------------------------
`define CMD_HEADER 8'hff
`define CMD_SIZE 8'h02
`define CMD_ESCAPE 8'hfe
`define RSP_ACK 8'h06
// ----------------------------------------
// Volatile offsets
// ----------------------------------------
`define ADDR_UID3 8'h68
`define ADDR_UID2 8'h69
`define ADDR_UID1 8'h6a
`define ADDR_UID0 8'h6b
`define ADDR_FAULT_MASK 8'h6c
`define ADDR_HOLD_TRAFFIC 8'h6e
`define ADDR_RX_GAIN_MODE 8'h6f
`define ADDR_LEGACY_COMPAT 8'h70
`define ADDR_FAULT_CODE 8'h79
// ----------------------------------------
// Non-volatile offsets
// ----------------------------------------
`define ADDR_UID3_NV 8'h1d
`define ADDR_UID0_NV 8'h20
`define ADDR_FAULT_MASK_NV 8'h21
`define ADDR_HOLD_TRAFFIC_NV 8'h23
`define ADDR_RX_GAIN_MODE_NV 8'h24
`define ADDR_LEGACY_COMPAT_NV 8'h25
// ----------------------------------------
// Field values and fault codes
// ----------------------------------------
`define HOLD_ON 8'h01
`define COMPAT_ON 8'h01
`define GAIN_MODE_MAX 8'h03
`define CODE_REG_WRITE_FAILURE 8'h13
`define CODE_RADIO_BUFFER_OVERFLOW 8'h09
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_UID 8'h00
`define RST_FAULT_MASK 8'hff
`define RST_HOLD_TRAFFIC 8'h00
`define RST_RX_GAIN_MODE 8'h00
`define RST_LEGACY_COMPAT 8'h00
`define RST_FAULT_CODE 8'h00
`endif

// [src/xcvr_cfg_pkg.sv]
// Types shared by the configuration register group
package xcvr_cfg_pkg;
  // Command parser states, Gray from ST_IDLE through ST_SEL to ST_RADDR
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SIZE = 3'b001,
    ST_SEL = 3'b011,
    ST_RADDR = 3'b010,
    ST_WVAL = 3'b110,
    ST_RESP = 3'b111
  } parse_state_t;
  // Receiver gain modes
  typedef enum logic [1:0] {
    GAIN_AUTO = 2'b00,
    GAIN_HIGH_SENS = 2'b01,
    GAIN_MID_LIN = 2'b10,
    GAIN_HIGH_LIN = 2'b11
  } gain_mode_t;
  // Configuration seen by the radio side
  typedef struct packed {
    logic [31:0] dest_uid;
    logic [15:0] dest_uid_short;
    logic uid_target_valid;
    gain_mode_t gain_mode;
    logic legacy_compat_en;
  } radio_cfg_t;
  // One fault event
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } fault_evt_t;
endpackage

// [bench/host_cmd_model.sv]
// Host-side model that issues framed register commands and collects answers
`include "xcvr_cfg_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model (
  input wire logic sys_clk,
  output var logic cmd_valid,
  output var logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  output var logic rsp_ready
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h5a;
    rsp_ready = 1'b0;
  end
  // ----------------------------------------
  // Byte and frame tasks
  // ----------------------------------------
  // One byte, held from a falling edge until taken; bytes go out in order
  task automatic put(input logic [7:0] b);
    int i;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_data = b;
    for (i = 0; i < 64 && cmd_ready !== 1'b1; i++) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // Release; data shows the inverse so a stale byte never looks valid
  task automatic drop();
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_data = ~cmd_data;
  endtask
  // Write frame, one register byte per frame; extra edge lets the store land
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    put(`CMD_HEADER);
    put(`CMD_SIZE);
    put(a);
    put(v);
    drop();
    @(negedge sys_clk);
  endtask
  // Read frame, then three answer bytes taken one per sampled edge
  task automatic rd(input logic [7:0] a, output logic [23:0] r);
    int i;
    int k;
    put(`CMD_HEADER);
    put(`CMD_SIZE);
    put(`CMD_ESCAPE);
    put(a);
    drop();
    rsp_ready = 1'b1;
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 64 && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
      r = {r[15:0], rsp_data};
      @(posedge sys_clk);
      @(negedge sys_clk);
    end
    rsp_ready = 1'b0;
  endtask
endmodule // host_cmd_model
`default_nettype wire

// [bench/tb_transceiver_config_registers.sv]
// Self-checking bench for the configuration register group
`include "xcvr_cfg_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_transceiver_config_registers;
  import xcvr_cfg_pkg::*;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  logic sys_clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready, cmd_line_n, uid_mode_en;
  logic fault_line, radio_valid, traffic_valid, traffic_ready;
  logic [7:0] cmd_data, rsp_data, radio_data, traffic_data, rssi_raw, rssi_comp;
  fault_evt_t fault_in;
  radio_cfg_t cfg;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 16;
  logic [7:0] q [$]; // Radio bytes still expected at the host side
  logic [7:0] addr_tab [16] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h23, 8'h24, 8'h25,
                                8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6e, 8'h6f, 8'h70};
  logic [7:0] ofs_tab [4] = '{8'h00, 8'h00, 8'h07, 8'h0a}; // Offset per gain mode
  logic [7:0] code_tab [7] = '{8'h08, 8'h13, 8'h13, 8'h20, 8'h42, 8'h44, 8'h09};
  logic [7:0] mask_tab [7] = '{8'h08, 8'h08, 8'h10, 8'h20, 8'h40, 8'h10, 8'hff};
  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  transceiver_config_registers u_transceiver_config_registers (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .cmd_line_n(cmd_line_n), .uid_mode_en(uid_mode_en), .fault_in(fault_in),
    .fault_line(fault_line), .radio_valid(radio_valid), .radio_data(radio_data),
    .traffic_valid(traffic_valid), .traffic_data(traffic_data), .traffic_ready(traffic_ready),
    .rssi_raw(rssi_raw), .rssi_comp(rssi_comp), .cfg(cfg));
  host_cmd_model u_host_cmd_model (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready));
  // 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Mask register resets to all ones, everything else to zero
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    return (a == `ADDR_FAULT_MASK || a == `ADDR_FAULT_MASK_NV) ? `RST_FAULT_MASK : 8'h00;
  endfunction
  // Single compare for every kind of result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read and compare whole answer: ack, echoed address, value
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [23:0] r;
    u_host_cmd_model.rd(a, r);
    chk(r, {`RSP_ACK, a, e});
  endtask
  // One-cycle fault pulse; code shows its inverse outside the pulse
  task automatic raise(input logic [7:0] c);
    @(negedge sys_clk);
    fault_in = '{valid: 1'b1, code: c};
    @(negedge sys_clk);
    fault_in = '{valid: 1'b0, code: ~c};
    @(negedge sys_clk);
  endtask
  // One radio byte, no back-pressure on that side
  task automatic push(input logic [7:0] b);
    @(negedge sys_clk);
    radio_valid = 1'b1;
    radio_data = b;
    q.push_back(b);
    @(negedge sys_clk);
    radio_valid = 1'b0;
    radio_data = ~b;
  endtask
  // Take queued bytes; each offered byte is checked before its taking edge
  task automatic drain();
    int i;
    traffic_ready = 1'b1;
    for (i = 0; i < 40 && q.size() > 0; i++) begin
      if (traffic_valid === 1'b1) chk(traffic_data, q.pop_front());
      @(negedge sys_clk);
    end
    traffic_ready = 1'b0;
    chk(32'(q.size()), 32'h0);
  endtask
  // Verdict, reached from the main sequence or the watchdog
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v [16];
    int i;
    rst = 1'b1;
    cmd_line_n = 1'b1;
    uid_mode_en = 1'b0;
    fault_in = '0;
    radio_valid = 1'b0;
    radio_data = 8'h00;
    traffic_ready = 1'b0;
    rssi_raw = 8'h00;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    // Reset values, plus an unmapped hole that reads zero
    for (i = 0; i < 16; i++) rd_chk(addr_tab[i], rst_val(addr_tab[i]));
    rd_chk(8'h6d, 8'h00);
    chk(fault_line, 32'h0);
    // Random values to every copy, then read back byte by byte
    for (i = 0; i < 16; i++) begin
      v[i] = 8'($random(seed));
      u_host_cmd_model.wr(addr_tab[i], v[i]);
    end
    for (i = 0; i < 16; i++) rd_chk(addr_tab[i], v[i]);
    chk(cfg.dest_uid, {v[8], v[9], v[10], v[11]});
    chk(cfg.dest_uid_short, {v[10], v[11]});
    for (i = 1; i >= 0; i--) begin
      uid_mode_en = i[0];
      @(negedge sys_clk);
      chk(cfg.uid_target_valid, i);
    end
    // Garbage outside a frame, then a frame with a bad size byte
    u_host_cmd_model.put(8'h12);
    u_host_cmd_model.put(8'h6c);
    u_host_cmd_model.put(`CMD_HEADER);
    u_host_cmd_model.put(8'h03);
    u_host_cmd_model.put(8'h6c);
    u_host_cmd_model.put(8'h34);
    u_host_cmd_model.drop();
    rd_chk(`ADDR_FAULT_MASK, v[12]);
    // Every gain code, with signal level offset where one is defined
    for (i = 0; i < 4; i++) begin
      u_host_cmd_model.wr(`ADDR_RX_GAIN_MODE, 8'(i));
      chk(cfg.gain_mode, i);
      rssi_raw = 8'($random(seed));
      repeat (3) @(negedge sys_clk);
      chk(rssi_comp, 8'(rssi_raw + ofs_tab[i]));
    end
    for (i = 1; i >= 0; i--) begin
      u_host_cmd_model.wr(`ADDR_LEGACY_COMPAT, 8'(i));
      chk(cfg.legacy_compat_en, i);
    end
    // Mask against code: line level, stored code, clear on read
    for (i = 0; i < 7; i++) begin
      u_host_cmd_model.wr(`ADDR_FAULT_MASK, mask_tab[i]);
      raise(code_tab[i]);
      chk(fault_line, 32'((code_tab[i] & mask_tab[i]) != 8'h00));
      rd_chk(`ADDR_FAULT_CODE, code_tab[i]);
      repeat (2) @(negedge sys_clk);
      chk(fault_line, 32'h0);
    end
    // Unread code overwritten by the newer one
    u_host_cmd_model.wr(`ADDR_FAULT_MASK, 8'hff);
    raise(8'h40);
    raise(8'h08);
    rd_chk(`ADDR_FAULT_CODE, 8'h08);
    // Write to the read-only code register fails and is reported
    u_host_cmd_model.wr(`ADDR_FAULT_MASK, 8'h10);
    u_host_cmd_model.wr(`ADDR_FAULT_CODE, 8'h55);
    chk(fault_line, 32'h1);
    rd_chk(`ADDR_FAULT_CODE, `CODE_REG_WRITE_FAILURE);
    // Hold off: byte offered at once even with command line low
    u_host_cmd_model.wr(`ADDR_HOLD_TRAFFIC, 8'h00);
    cmd_line_n = 1'b0;
    push(8'($random(seed)));
    repeat (2) @(negedge sys_clk);
    chk(traffic_valid, 32'h1);
    drain();
    // Hold on: nothing while line low, all bytes in order once high
    u_host_cmd_model.wr(`ADDR_HOLD_TRAFFIC, `HOLD_ON);
    repeat (4) @(negedge sys_clk);
    for (i = 0; i < 16; i++) push(8'($random(seed)));
    // One byte past capacity is lost and reported; mask 10 keeps the line low
    push(8'($random(seed)));
    void'(q.pop_back());
    chk(fault_line, 32'h0);
    rd_chk(`ADDR_FAULT_CODE, `CODE_RADIO_BUFFER_OVERFLOW);
    traffic_ready = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(traffic_valid, 32'h0);
    traffic_ready = 1'b0;
    cmd_line_n = 1'b1;
    drain();
    wrap_up();
  end
endmodule // tb_transceiver_config_registers
`default_nettype wire
